//--- verilog/fault_lock_config_register.sv
// module: second fault lock configuration register behind an APB slave
// ----------------------------------------------------------------
// Summary of operation
// - bit 30 enables abnormal speed lock
// - bit 29 enables abnormal back-emf lock
// - bit 28 enables no-motor lock
// - bits 27:25 overspeed threshold 130..200 percent
// - bits 24:22 low back-emf threshold 40..70 percent
// - bits 21:19 no-motor current threshold select
// - bits 18:15 hardware current-limit lock response
// ----------------------------------------------------------------
`timescale 1ns/10ps
module fault_lock_config_register (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // lock detector settings
    output logic abnormalSpeedLockEnable,
    output logic abnormalBackemfLockEnable,
    output logic noMotorLockEnable,
    output logic [7:0] overspeedLockThreshold,
    output logic [9:0] lowBackemfLockThreshold,
    output logic [10:0] noMotorCurrentThreshold,
    output logic [1:0] hardwareCurrentLockResponse,
    output logic [1:0] hardwareCurrentLockBrake,
    output logic [31:0] faultLockConfigSecond,
    // interrupt
    output logic irq
);
    import fault_lock_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] cfg_ff, nxt_cfg;
    logic [IRQ_WIDTH-1:0] status_ff, nxt_status;
    logic [IRQ_WIDTH-1:0] mask_ff, nxt_mask;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic irq_ff, nxt_irq;
    logic spdEn_ff, bemfEn_ff, nomEn_ff;
    logic [7:0] ospd_ff;
    logic [9:0] lbemf_ff;
    logic [10:0] nomThr_ff;
    logic [1:0] hwResp_ff, hwBrake_ff;

    cfg_decode_if dec ();

    lock_threshold_decode u_decode (
        .cfg(dec.decoder)
    );

    function automatic logic addrHit(input logic [11:0] a, input logic [11:0] target);
        addrHit = (a == target);
    endfunction : addrHit

    // ----------------------------------------------------------------
    // apb access and interrupt status
    // ----------------------------------------------------------------
    logic access, wrAccess, hitCfg, hitStatus, hitMask, bad;
    logic [IRQ_WIDTH-1:0] events;

    // one wait state: pready rises the cycle after the first access edge
    always_comb begin
        access = psel && penable && !pready_ff;
        wrAccess = access && pwrite;
        hitCfg = addrHit(paddr, CFG_SECOND_ADDR);
        hitStatus = addrHit(paddr, IRQ_STATUS_ADDR);
        hitMask = addrHit(paddr, IRQ_MASK_ADDR);
        bad = !(hitCfg || hitStatus || hitMask);

        nxt_cfg = cfg_ff;
        nxt_mask = mask_ff;
        nxt_prdata = prdata_ff;
        nxt_pready = access;
        nxt_pslverr = access && bad;
        events = '0;

        if (wrAccess && hitCfg) begin
            nxt_cfg = pwdata;
            events[IRQ_WRITE_BIT] = 1'b1;
            events[IRQ_ENABLE_CHG_BIT] = (pwdata[SPEED_EN_BIT] != cfg_ff[SPEED_EN_BIT])
                || (pwdata[BEMF_EN_BIT] != cfg_ff[BEMF_EN_BIT])
                || (pwdata[NOMOTOR_EN_BIT] != cfg_ff[NOMOTOR_EN_BIT]);
        end
        if (wrAccess && hitMask) begin
            nxt_mask = pwdata[IRQ_WIDTH-1:0];
        end
        if (access && bad) begin
            events[IRQ_BAD_ADDR_BIT] = 1'b1;
        end

        // write-one-to-clear, a same-cycle event wins over the clear
        nxt_status = status_ff;
        if (wrAccess && hitStatus) begin
            nxt_status = status_ff & ~pwdata[IRQ_WIDTH-1:0];
        end
        nxt_status = nxt_status | events;

        if (access && !pwrite) begin
            if (hitCfg) begin
                nxt_prdata = cfg_ff;
            end else if (hitStatus) begin
                nxt_prdata = {{(32-IRQ_WIDTH){1'b0}}, status_ff};
            end else if (hitMask) begin
                nxt_prdata = {{(32-IRQ_WIDTH){1'b0}}, mask_ff};
            end else begin
                nxt_prdata = 32'h00000000;
            end
        end
        nxt_irq = |(nxt_status & nxt_mask);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_ff <= CFG_SECOND_RESET;
            status_ff <= IRQ_WIDTH'(IRQ_RESET);
            mask_ff <= IRQ_WIDTH'(IRQ_RESET);
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
        end
    end

    // ----------------------------------------------------------------
    // decoded settings, registered so outputs come from flip-flops
    // ----------------------------------------------------------------
    // decoded from the next value so settings change on the same edge as cfg_ff
    assign dec.raw = nxt_cfg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            spdEn_ff <= 1'b0;
            bemfEn_ff <= 1'b0;
            nomEn_ff <= 1'b0;
            ospd_ff <= OVERSPEED_BASE_PCT;
            lbemf_ff <= 10'h190;
            nomThr_ff <= 11'h04B;
            hwResp_ff <= 2'(RESP_LATCHED);
            hwBrake_ff <= 2'h0;
        end else begin
            spdEn_ff <= nxt_cfg[SPEED_EN_BIT];
            bemfEn_ff <= nxt_cfg[BEMF_EN_BIT];
            nomEn_ff <= nxt_cfg[NOMOTOR_EN_BIT];
            ospd_ff <= dec.overspeedPct;
            lbemf_ff <= dec.lowBemfPermille;
            nomThr_ff <= dec.noMotorMilliamp;
            hwResp_ff <= dec.hwResponse;
            hwBrake_ff <= dec.hwBrakeSel;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign faultLockConfigSecond = cfg_ff;
    assign abnormalSpeedLockEnable = spdEn_ff;
    assign abnormalBackemfLockEnable = bemfEn_ff;
    assign noMotorLockEnable = nomEn_ff;
    assign overspeedLockThreshold = ospd_ff;
    assign lowBackemfLockThreshold = lbemf_ff;
    assign noMotorCurrentThreshold = nomThr_ff;
    assign hardwareCurrentLockResponse = hwResp_ff;
    assign hardwareCurrentLockBrake = hwBrake_ff;

endmodule : fault_lock_config_register

//--- verilog/fault_lock_pkg.sv
// package: register map, field layout and decode constants for the fault lock config bank
package fault_lock_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] CFG_SECOND_OFFSET = 12'h092;
    localparam logic [11:0] CFG_SECOND_ADDR = 12'h248;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h400;
    localparam logic [11:0] IRQ_MASK_ADDR = 12'h404;
    localparam logic [31:0] CFG_SECOND_RESET = 32'h00000000;
    localparam logic [31:0] IRQ_RESET = 32'h00000000;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SPEED_EN_BIT = 30;
    localparam int BEMF_EN_BIT = 29;
    localparam int NOMOTOR_EN_BIT = 28;
    localparam int OVERSPEED_LSB = 25;
    localparam int LOWBEMF_LSB = 22;
    localparam int NOMOTOR_THR_LSB = 19;
    localparam int HWLOCK_LSB = 15;

    // ----------------------------------------------------------------
    // interrupt status bits
    // ----------------------------------------------------------------
    localparam int IRQ_WRITE_BIT = 0;
    localparam int IRQ_ENABLE_CHG_BIT = 1;
    localparam int IRQ_BAD_ADDR_BIT = 2;
    localparam int IRQ_WIDTH = 3;

    // ----------------------------------------------------------------
    // decoded threshold units
    // ----------------------------------------------------------------
    // overspeed in percent, low back-emf in tenths of percent, current in mA
    localparam logic [7:0] OVERSPEED_BASE_PCT = 8'h82;
    localparam logic [7:0] OVERSPEED_STEP_PCT = 8'h0A;
    localparam logic [3:0] HWLOCK_RETRY_CODE = 4'h4;
    localparam logic [3:0] HWLOCK_OFF_CODE = 4'h8;

    typedef enum {RESP_LATCHED, RESP_RETRY, RESP_DISABLED} hw_resp_t;

endpackage : fault_lock_pkg

//--- verilog/cfg_decode_if.sv
// interface: raw register value out to the decoder, decoded settings back
`timescale 1ns/10ps
interface cfg_decode_if;
    logic [31:0] raw;
    logic [7:0] overspeedPct;
    logic [9:0] lowBemfPermille;
    logic [10:0] noMotorMilliamp;
    logic [1:0] hwResponse;
    logic [1:0] hwBrakeSel;

    modport owner (output raw, input overspeedPct, lowBemfPermille, noMotorMilliamp,
        hwResponse, hwBrakeSel);
    modport decoder (input raw, output overspeedPct, lowBemfPermille, noMotorMilliamp,
        hwResponse, hwBrakeSel);
endinterface : cfg_decode_if

//--- verilog/lock_threshold_decode.sv
// module: decodes threshold codes of the lock config into physical units
`timescale 1ns/10ps
module lock_threshold_decode (
    // register value and decoded settings
    cfg_decode_if.decoder cfg
);
    import fault_lock_pkg::*;

    function automatic logic [9:0] bemfPermille(input logic [2:0] code);
        case (code)
            3'h0: bemfPermille = 10'h190;
            3'h1: bemfPermille = 10'h1C2;
            3'h2: bemfPermille = 10'h1F4;
            3'h3: bemfPermille = 10'h226;
            3'h4: bemfPermille = 10'h258;
            3'h5: bemfPermille = 10'h28A;
            3'h6: bemfPermille = 10'h2A3;
            default: bemfPermille = 10'h2BC;
        endcase
    endfunction : bemfPermille

    function automatic logic [10:0] currentMilliamp(input logic [2:0] code);
        case (code)
            3'h0, 3'h1: currentMilliamp = 11'h04B;
            3'h2: currentMilliamp = 11'h064;
            3'h3: currentMilliamp = 11'h07D;
            3'h4: currentMilliamp = 11'h0FA;
            3'h5: currentMilliamp = 11'h1F4;
            3'h6: currentMilliamp = 11'h2EE;
            default: currentMilliamp = 11'h3E8;
        endcase
    endfunction : currentMilliamp

    logic [2:0] spdCode;
    logic [3:0] hwCode;

    always_comb begin
        spdCode = cfg.raw[OVERSPEED_LSB +: 3];
        hwCode = cfg.raw[HWLOCK_LSB +: 4];
        cfg.overspeedPct = 8'(OVERSPEED_BASE_PCT + OVERSPEED_STEP_PCT * spdCode);
        cfg.lowBemfPermille = bemfPermille(cfg.raw[LOWBEMF_LSB +: 3]);
        cfg.noMotorMilliamp = currentMilliamp(cfg.raw[NOMOTOR_THR_LSB +: 3]);
        if (hwCode >= HWLOCK_OFF_CODE) begin
            cfg.hwResponse = 2'(RESP_DISABLED);
        end else if (hwCode >= HWLOCK_RETRY_CODE) begin
            cfg.hwResponse = 2'(RESP_RETRY);
        end else begin
            cfg.hwResponse = 2'(RESP_LATCHED);
        end
        // 0 tristate, 2 high side brake, 3 low side brake (code 1 tristates too)
        cfg.hwBrakeSel = (hwCode[1:0] == 2'h1) ? 2'h0 : hwCode[1:0];
    end

endmodule : lock_threshold_decode

//--- sim/fault_lock_config_register_sva.sv
// checker: apb timing and field decode of the fault lock config bank
`timescale 1ns/10ps
module fault_lock_config_register_sva (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // lock detector settings
    input wire logic abnormalSpeedLockEnable,
    input wire logic abnormalBackemfLockEnable,
    input wire logic noMotorLockEnable,
    input wire logic [7:0] overspeedLockThreshold,
    input wire logic [9:0] lowBackemfLockThreshold,
    input wire logic [10:0] noMotorCurrentThreshold,
    input wire logic [1:0] hardwareCurrentLockResponse,
    input wire logic [1:0] hardwareCurrentLockBrake,
    input wire logic [31:0] faultLockConfigSecond,
    // interrupt
    input wire logic irq
);
    import fault_lock_pkg::*;
    localparam int LB[8] = '{400, 450, 500, 550, 600, 650, 675, 700};
    localparam int NM[8] = '{75, 75, 100, 125, 250, 500, 750, 1000};
    logic [31:0] c;
    logic hit;
    logic ok;
    assign c = faultLockConfigSecond;
    assign hit = paddr == CFG_SECOND_ADDR;
    assign ok = hit || paddr == IRQ_STATUS_ADDR || paddr == IRQ_MASK_ADDR;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // bus and fields
    // ----------------------------------------------------------------
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no answer after wait state");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err; pready |-> pslverr == !ok; endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_rd; pready && !pwrite && hit |-> prdata == c; endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_wr; pready && pwrite && hit |-> c == pwdata; endproperty
    a_wr: assert property (p_wr) else $error("write not taken");
    property p_hold; !$stable(c) |-> pready && pwrite && hit; endproperty
    a_hold: assert property (p_hold) else $error("register changed unasked");
    property p_en; {abnormalSpeedLockEnable, abnormalBackemfLockEnable,
        noMotorLockEnable} == c[30:28]; endproperty
    a_en: assert property (p_en) else $error("enable bits wrong");
    property p_spd; overspeedLockThreshold == 8'(130 + 10 * c[27:25]); endproperty
    a_spd: assert property (p_spd) else $error("overspeed threshold wrong");
    property p_bemf; lowBackemfLockThreshold == 10'(LB[c[24:22]]); endproperty
    a_bemf: assert property (p_bemf) else $error("back-emf threshold wrong");
    property p_nm; noMotorCurrentThreshold == 11'(NM[c[21:19]]); endproperty
    a_nm: assert property (p_nm) else $error("no-motor threshold wrong");
    property p_resp; hardwareCurrentLockResponse == (c[18] ? 2'h2 : {1'h0, c[17]});
    endproperty
    a_resp: assert property (p_resp) else $error("lock response wrong");
    property p_brake; hardwareCurrentLockBrake == (c[16:15] == 2'h1 ? 2'h0 : c[16:15]);
    endproperty
    a_brake: assert property (p_brake) else $error("lock brake select wrong");
endmodule : fault_lock_config_register_sva

bind fault_lock_config_register fault_lock_config_register_sva u_sva (.*);

//--- sim/tb_top.sv
// testbench: apb traffic against a behavioural model of the fault lock config bank
`timescale 1ns/10ps
module tb_top;
    import fault_lock_pkg::*;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq, e;
    logic abnormalSpeedLockEnable, abnormalBackemfLockEnable, noMotorLockEnable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, faultLockConfigSecond, q, v, seed, cfgM;
    logic [7:0] overspeedLockThreshold;
    logic [9:0] lowBackemfLockThreshold;
    logic [10:0] noMotorCurrentThreshold;
    logic [1:0] hardwareCurrentLockResponse, hardwareCurrentLockBrake;
    logic [2:0] stM, mkM;
    int n_mismatch, compares;
    int LB[8] = '{400, 450, 500, 550, 600, 650, 675, 700};
    int NM[8] = '{75, 75, 100, 125, 250, 500, 750, 1000};

    fault_lock_config_register u_fault_lock_config_register (.*);

    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    task automatic end_of_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", nm, x, s);
        end
    endtask : chk

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // ----------------------------------------------------------------
    // apb master with model update; call right after a rising edge
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        logic ok;
        k = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (k == 20) n_mismatch++;
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
        ok = a == CFG_SECOND_ADDR || a == IRQ_STATUS_ADDR || a == IRQ_MASK_ADDR;
        chk("pslverr", e, !ok);
        if (!ok) stM[IRQ_BAD_ADDR_BIT] = 1'h1;
        if (!w) chk("rdata", q, !ok ? 0 : a == CFG_SECOND_ADDR ? cfgM :
            a == IRQ_STATUS_ADDR ? {29'h0, stM} : {29'h0, mkM});
        else if (a == CFG_SECOND_ADDR) begin
            if (d[30:28] != cfgM[30:28]) stM[IRQ_ENABLE_CHG_BIT] = 1'h1;
            stM[IRQ_WRITE_BIT] = 1'h1;
            cfgM = d;
        end else if (a == IRQ_STATUS_ADDR) stM = stM & ~d[2:0];
        else if (a == IRQ_MASK_ADDR) mkM = d[2:0];
    endtask : apb

    task automatic chkAll();
        chk("cfg", faultLockConfigSecond, cfgM);
        chk("enables", {abnormalSpeedLockEnable, abnormalBackemfLockEnable,
            noMotorLockEnable}, cfgM[30:28]);
        chk("overspeed", overspeedLockThreshold, 130 + 10 * cfgM[27:25]);
        chk("lowbemf", lowBackemfLockThreshold, LB[cfgM[24:22]]);
        chk("nomotor", noMotorCurrentThreshold, NM[cfgM[21:19]]);
        chk("response", hardwareCurrentLockResponse, cfgM[18] ? 2 : cfgM[17]);
        chk("brake", hardwareCurrentLockBrake,
            cfgM[16:15] == 2'h1 ? 2'h0 : cfgM[16:15]);
        chk("irq", irq, |(stM & mkM));
    endtask : chkAll

    initial begin
        rst = 1'h1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h6BB42ED5;
        cfgM = '0;
        stM = '0;
        mkM = '0;
        n_mismatch = 0;
        compares = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        chkAll();
        apb(1'h0, CFG_SECOND_ADDR, 32'h0);
        apb(1'h1, IRQ_MASK_ADDR, 32'h7);
        // every code of every field, random filler elsewhere
        for (int i = 0; i < 16; i++) begin
            v = rnd();
            v[27:15] = {i[2:0], i[2:0], i[2:0], i[3:0]};
            apb(1'h1, CFG_SECOND_ADDR, v);
            apb(1'h0, CFG_SECOND_ADDR, rnd());
            chkAll();
            apb(i[0], IRQ_STATUS_ADDR, rnd());
            v = rnd();
            apb(i[1], {v[11:2], 2'h0}, rnd());
            apb(1'h0, IRQ_MASK_ADDR, 32'h0);
            chkAll();
        end
        apb(1'h1, IRQ_STATUS_ADDR, 32'h7);
        apb(1'h0, IRQ_STATUS_ADDR, 32'h0);
        chkAll();
        apb(1'h1, 12'h300, 32'hFFFFFFFF);
        apb(1'h1, IRQ_MASK_ADDR, 32'h3);
        chkAll();
        // mid-run reset must clear every field and the interrupt state
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        cfgM = '0;
        stM = '0;
        mkM = '0;
        @(posedge mclk);
        chkAll();
        apb(1'h0, CFG_SECOND_ADDR, 32'h0);
        end_of_test();
    end

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        end_of_test();
    end
endmodule : tb_top
